// *** verilog/ceis_top.sv ***
// APB register file, edge selection and interrupt logic for comparator channels 0..11
`timescale 1ns/1ps
`default_nettype none
module ceis_top
	import ceis_pkg::*;
#(
	parameter int SETTLE = ceis_pkg::SETTLE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ceis_pkg::ADDR_W-1:0] paddr,
	input wire logic [ceis_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [ceis_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [ceis_pkg::NCH-1:0] comp_in,
	output logic [ceis_pkg::THR_USED_W-1:0] thr_sel,
	output logic [2*ceis_pkg::NCH-1:0] chan_thr,
	output logic irq
);
	import ceis_pkg::*;

	// Byte-lane merge for 24-bit registers
	function automatic logic [REG_W-1:0] lane_merge(
		input logic [REG_W-1:0] old_val,
		input logic [DATA_W-1:0] wdata,
		input logic [3:0] strb
	);
		logic [REG_W-1:0] res;
		res = old_val;
		for (int b = 0; b < REG_W / 8; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = wdata[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Registers
	logic [REG_W-1:0] thr_reg;
	logic [REG_W-1:0] thr_next;
	logic [REG_W-1:0] sel_reg;
	logic [REG_W-1:0] sel_next;
	logic [NCH-1:0] status_reg;
	logic [NCH-1:0] status_next;
	logic [NCH-1:0] mask_reg;
	logic [NCH-1:0] mask_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic [DATA_W-1:0] prdata_reg;
	logic irq_reg;
	logic [2*NCH-1:0] chan_thr_reg;
	logic [2*NCH-1:0] chan_thr_next;

	// Bus decode
	wire access = psel & penable;
	wire take = access & pready_reg;
	wire first = access & ~pready_reg;
	wire wr_take = take & pwrite;
	wire aligned = (paddr[1:0] == 2'b00);
	wire hit_thr = aligned & (paddr == ADDR_THR);
	wire hit_sel = aligned & (paddr == ADDR_SEL_LO);
	wire hit_status = aligned & (paddr == ADDR_STATUS);
	wire hit_mask = aligned & (paddr == ADDR_MASK);
	wire hit_level = aligned & (paddr == ADDR_LEVEL);
	wire mapped = hit_thr | hit_sel | hit_status | hit_mask | hit_level;
	wire wr_thr = wr_take & hit_thr;
	wire wr_sel = wr_take & hit_sel;
	wire wr_status = wr_take & hit_status;
	wire wr_mask = wr_take & hit_mask;

	// Comparator front end
	logic [NCH-1:0] level;
	logic [NCH-1:0] rise;
	logic [NCH-1:0] fall;

	ceis_edge_det #(
		.N(NCH)
	) u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.comp_async(comp_in),
		.level(level),
		.rise(rise),
		.fall(fall)
	);

	// Threshold register: reserved bits stay zero
	logic [REG_W-1:0] thr_merged;
	assign thr_merged = lane_merge(thr_reg, pwdata, pstrb);
	assign thr_next = wr_thr ? {{(REG_W - THR_USED_W){1'b0}}, thr_merged[THR_USED_W-1:0]} : thr_reg;

	assign sel_next = wr_sel ? lane_merge(sel_reg, pwdata, pstrb) : sel_reg;

	logic [REG_W-1:0] mask_merged;
	assign mask_merged = lane_merge({{(REG_W - NCH){1'b0}}, mask_reg}, pwdata, pstrb);
	assign mask_next = wr_mask ? mask_merged[NCH-1:0] : mask_reg;

	// Write-one-to-clear with byte lanes
	logic [REG_W-1:0] clr_merged;
	logic [NCH-1:0] status_clr;
	assign clr_merged = lane_merge({REG_W{1'b0}}, pwdata, pstrb);
	assign status_clr = wr_status ? clr_merged[NCH-1:0] : {NCH{1'b0}};

	// Per-group settle window after a threshold change
	logic [NGRP-1:0] blank;
	logic [SETTLE_W-1:0] settle_cnt_reg [NGRP];
	logic [SETTLE_W-1:0] settle_cnt_next [NGRP];
	// Threshold flop, synchroniser and edge stage delay a crossing by five cycles
	localparam int EDGE_LAT = 5;
	localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE + EDGE_LAT);

	genvar g;
	generate
		for (g = 0; g < NGRP; g++) begin : g_grp
			wire changed = wr_thr &
				(thr_next[THR_FIELD_LSB + THR_FIELD_W*g +: THR_FIELD_W] !=
				thr_reg[THR_FIELD_LSB + THR_FIELD_W*g +: THR_FIELD_W]);
			// Comparator output is not trusted while the level moves
			assign settle_cnt_next[g] = changed ? SETTLE_LOAD :
				(settle_cnt_reg[g] != '0) ? settle_cnt_reg[g] - SETTLE_W'(1) : settle_cnt_reg[g];
			assign blank[g] = (settle_cnt_reg[g] != '0);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					settle_cnt_reg[g] <= '0;
				end else if (ce) begin
					settle_cnt_reg[g] <= settle_cnt_next[g];
				end
			end
		end
	endgenerate

	// Per-channel edge qualification
	logic [NCH-1:0] evt;

	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			localparam int GI = i / GRP_SIZE;
			ceis_edge_t mode;
			logic hit;
			assign mode = ceis_edge_t'(sel_reg[SEL_FIELD_LSB + SEL_FIELD_W*i +: SEL_FIELD_W]);
			assign chan_thr_next[2*i +: 2] = thr_reg[THR_FIELD_LSB + THR_FIELD_W*GI +: THR_FIELD_W];

			always_comb begin
				hit = 1'b0;
				unique case (mode)
					CEIS_EDGE_NONE: begin
						hit = 1'b0;
					end
					CEIS_EDGE_RISE: begin
						hit = rise[i];
					end
					CEIS_EDGE_FALL: begin
						hit = fall[i];
					end
					CEIS_EDGE_BOTH: begin
						hit = rise[i] | fall[i];
					end
				endcase
			end

			assign evt[i] = hit & ~blank[GI];
		end
	endgenerate

	// Sticky status: a new event beats a clear
	assign status_next = (status_reg & ~status_clr) | evt;

	// Read path
	logic [DATA_W-1:0] rd_mux;
	assign rd_mux = hit_thr ? {{(DATA_W - REG_W){1'b0}}, thr_reg} :
		hit_sel ? {{(DATA_W - REG_W){1'b0}}, sel_reg} :
		hit_status ? {{(DATA_W - NCH){1'b0}}, status_reg} :
		hit_mask ? {{(DATA_W - NCH){1'b0}}, mask_reg} :
		hit_level ? {{(DATA_W - NCH){1'b0}}, level} :
		{DATA_W{1'b0}};

	// One wait state keeps every bus output on a flop
	assign pready_next = first;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else if (ce) begin
			pready_reg <= pready_next;
			if (first) begin
				pslverr_reg <= ~mapped;
				prdata_reg <= pwrite ? {DATA_W{1'b0}} : rd_mux;
			end
		end
	end

	// zero code selects the 2 V level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_reg <= RST_THR;
			chan_thr_reg <= '0;
		end else if (ce) begin
			thr_reg <= thr_next;
			chan_thr_reg <= chan_thr_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= RST_SEL_LO;
		end else if (ce) begin
			sel_reg <= sel_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= RST_STATUS;
			mask_reg <= RST_MASK;
			irq_reg <= 1'b0;
		end else if (ce) begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			irq_reg <= |(status_next & mask_next);
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign thr_sel = thr_reg[THR_USED_W-1:0];
	assign chan_thr = chan_thr_reg;
	assign irq = irq_reg;

endmodule
`default_nettype wire

// *** verilog/ceis_pkg.sv ***
// Shared constants and types for the comparator edge interrupt selector
package ceis_pkg;

	// Channel and group geometry
	localparam int NCH = 12;
	localparam int GRP_SIZE = 4;
	localparam int NGRP = NCH / GRP_SIZE;
	localparam int NGRP_ALL = 6;
	localparam int REG_W = 24;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 10;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_THR = 8'h21;
	localparam logic [7:0] IDX_SEL_LO = 8'h22;
	localparam logic [7:0] IDX_STATUS = 8'h30;
	localparam logic [7:0] IDX_MASK = 8'h31;
	localparam logic [7:0] IDX_LEVEL = 8'h32;
	localparam logic [ADDR_W-1:0] ADDR_THR = {IDX_THR, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_SEL_LO = {IDX_SEL_LO, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_LEVEL = {IDX_LEVEL, 2'b00};

	// Field layout
	localparam int THR_FIELD_W = 2;
	localparam int THR_FIELD_LSB = 0;
	localparam int THR_USED_W = THR_FIELD_W * NGRP_ALL;
	localparam int SEL_FIELD_W = 2;
	localparam int SEL_FIELD_LSB = 0;

	// Reset values
	localparam logic [REG_W-1:0] RST_THR = 24'h000000;
	localparam logic [REG_W-1:0] RST_SEL_LO = 24'h000000;
	localparam logic [NCH-1:0] RST_STATUS = 12'h000;
	localparam logic [NCH-1:0] RST_MASK = 12'h000;

	// Threshold codes, in code order 0..3
	typedef enum logic [1:0] {
		CEIS_THR_2V0,
		CEIS_THR_2V7,
		CEIS_THR_3V0,
		CEIS_THR_4V0
	} ceis_thr_t;
	localparam int THR_MV_2V0 = 2000;
	localparam int THR_MV_2V7 = 2700;
	localparam int THR_MV_3V0 = 3000;
	localparam int THR_MV_4V0 = 4000;

	// Edge selector codes, in code order 0..3
	typedef enum logic [1:0] {
		CEIS_EDGE_NONE,
		CEIS_EDGE_RISE,
		CEIS_EDGE_FALL,
		CEIS_EDGE_BOTH
	} ceis_edge_t;

	// Timing
	localparam int CLK_NS = 40;
	localparam int SETTLE_NS = 160;
	localparam int SETTLE_RAW = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
	localparam int SETTLE_W = 4;

endpackage

// *** verilog/ceis_edge_det.sv ***
// Comparator input synchroniser, agreement filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module ceis_edge_det #(
	parameter int N = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [N-1:0] comp_async,
	output logic [N-1:0] level,
	output logic [N-1:0] rise,
	output logic [N-1:0] fall
);

	logic [N-1:0] s1_reg;
	logic [N-1:0] s2_reg;
	logic [N-1:0] s3_reg;
	logic [N-1:0] level_reg;
	logic [N-1:0] agree;
	logic [N-1:0] level_next;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
		end else if (ce) begin
			s1_reg <= comp_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_ch
			assign agree[i] = s2_reg[i] ~^ s3_reg[i];
			assign level_next[i] = agree[i] ? s3_reg[i] : level_reg[i];
			assign rise[i] = ce & level_next[i] & ~level_reg[i];
			assign fall[i] = ce & ~level_next[i] & level_reg[i];
		end
	endgenerate

	assign level = level_reg;

endmodule
`default_nettype wire

// *** tb/ceis_sva.sv ***
// Port-level checker for the comparator edge interrupt selector
`timescale 1ns/1ps
`default_nettype none
module ceis_sva
	import ceis_pkg::*;
#(
	parameter int SETTLE = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NCH-1:0] comp_in,
	input wire logic [THR_USED_W-1:0] thr_sel,
	input wire logic [2*NCH-1:0] chan_thr,
	input wire logic irq
);
	logic [NCH-1:0] prev_comp;
	logic [REG_W-1:0] sel_sh;
	logic [NCH-1:0] mask_sh;
	wire logic [NCH-1:0] rise_en;
	wire logic [NCH-1:0] fall_en;
	wire logic wr_done = psel && penable && pready && pwrite;
	// Blanking after threshold writes is not modelled; keep those writes masked
	// Clock enable low freezes the front end, so edges count only while it is high
	wire logic hit = ce && |(((comp_in & ~prev_comp & rise_en) | (~comp_in & prev_comp & fall_en)) & mask_sh);
	for (genvar n = 0; n < NCH; n++) begin : g_en
		assign rise_en[n] = sel_sh[2*n];
		assign fall_en[n] = sel_sh[2*n+1];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_comp <= '0;
			sel_sh <= '0;
			mask_sh <= '0;
		end else begin
			if (ce) begin
				prev_comp <= comp_in;
			end
			if (wr_done && paddr == ADDR_SEL_LO) sel_sh <= pwdata[REG_W-1:0];
			if (wr_done && paddr == ADDR_MASK) mask_sh <= pwdata[NCH-1:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
		else $error("pready not after one wait");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_err_unaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == '0)
		else $error("unaligned not refused");
	chk_thr_write: assert property (wr_done && paddr == ADDR_THR |=> thr_sel == $past(pwdata[THR_USED_W-1:0]))
		else $error("threshold write lost");
	chk_group_map: assert property (chan_thr == $past({{4{thr_sel[5:4]}}, {4{thr_sel[3:2]}}, {4{thr_sel[1:0]}}}))
		else $error("group threshold map wrong");
	chk_reset_quiet: assert property ($rose(presetn) |-> !irq [*6])
		else $error("irq after reset");
	chk_edge_irq: assert property (hit && !irq |-> ##[3:5] irq)
		else $error("selected edge gave no irq");
	chk_irq_cause: assert property ($rose(irq) |-> $past(hit, 3) || $past(hit, 4) || $past(hit, 5))
		else $error("irq without selected edge");
endmodule
bind ceis_top ceis_sva #(.SETTLE(SETTLE)) sva_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .comp_in, .thr_sel, .chan_thr, .irq);
`default_nettype wire

// *** tb/ceis_comp_model.sv ***
// Comparator front end turning input voltages into channel results
`timescale 1ns/1ps
`default_nettype none
module ceis_comp_model
	import ceis_pkg::*;
(
	input wire logic pclk,
	input wire logic [2*NCH-1:0] chan_thr,
	input wire logic [12*NCH-1:0] mv,
	output logic [NCH-1:0] comp_in
);
	int lvl [4] = '{THR_MV_2V0, THR_MV_2V7, THR_MV_3V0, THR_MV_4V0};
	always @(posedge pclk) begin
		for (int n = 0; n < NCH; n++) begin
			comp_in[n] <= int'(mv[12*n +: 12]) > lvl[chan_thr[2*n +: 2]];
		end
	end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Register and interrupt testbench for the comparator edge interrupt selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
	import ceis_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [12*NCH-1:0] mv = '0;
	wire logic [DATA_W-1:0] prdata;
	wire logic pready;
	wire logic pslverr;
	wire logic irq;
	wire logic [NCH-1:0] comp_in;
	wire logic [THR_USED_W-1:0] thr_sel;
	wire logic [2*NCH-1:0] chan_thr;
	int error_cnt = 0;
	int total_checks = 0;
	int lvl [4] = '{THR_MV_2V0, THR_MV_2V7, THR_MV_3V0, THR_MV_4V0};
	logic [DATA_W-1:0] rdat;
	logic rerr;
	initial begin
		forever #20 pclk = ~pclk;
	end
	ceis_top dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
		.prdata, .pready, .pslverr, .comp_in, .thr_sel, .chan_thr, .irq);
	ceis_comp_model model_u (.pclk, .chan_thr, .mv, .comp_in);
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic ee);
		apb(1'b0, a, '0);
		`CHK(rdat, e)
		`CHK(rerr, ee)
	endtask
	// Moves one input, then checks irq and status and clears
	task automatic step(input int ch, input logic [11:0] v, input logic xi, input logic xs);
		@(posedge pclk);
		mv[12*ch +: 12] <= v;
		repeat (10) @(posedge pclk);
		`CHK(irq, xi)
		rd(ADDR_STATUS, DATA_W'(xs) << ch, 1'b0);
		apb(1'b1, ADDR_STATUS, 32'h00000FFF);
		repeat (4) @(posedge pclk);
		`CHK(irq, 1'b0)
	endtask
	task automatic results;
		$display("Checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_THR, '0, 1'b0);
		rd(ADDR_SEL_LO, '0, 1'b0);
		rd(ADDR_MASK, '0, 1'b0);
		rd(ADDR_STATUS, '0, 1'b0);
		apb(1'b1, ADDR_SEL_LO, 32'hFFFFFFFF);
		rd(ADDR_SEL_LO, 32'h00FFFFFF, 1'b0);
		apb(1'b1, ADDR_THR, 32'hFFFFFFFF);
		rd(ADDR_THR, 32'h00000FFF, 1'b0);
		apb(1'b1, ADDR_THR, '0);
		rd(10'h3FC, '0, 1'b1);
		rd(ADDR_SEL_LO + 10'h002, '0, 1'b1);
		$display("Test registers done");
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ADDR_SEL_LO, DATA_W'(c) << (6 * c + 4));
			apb(1'b1, ADDR_MASK, 32'h1 << (3 * c + 2));
			step(3 * c + 2, 12'd2500, c[0], c[0]);
			step(3 * c + 2, 12'd1000, c[1], c[1]);
		end
		apb(1'b1, ADDR_SEL_LO, 32'h00000001);
		apb(1'b1, ADDR_MASK, '0);
		step(0, 12'd2500, 1'b0, 1'b1);
		$display("Test edges done");
		apb(1'b1, ADDR_SEL_LO, '0);
		mv[12 +: 12] <= 12'd2850;
		mv[60 +: 12] <= 12'd2850;
		for (int t = 0; t < 4; t++) begin
			apb(1'b1, ADDR_THR, DATA_W'(t) << 2);
			repeat (12) @(posedge pclk);
			`CHK(chan_thr, {8'h00, {4{t[1:0]}}, 8'h00})
			rd(ADDR_LEVEL, 32'h3 | (DATA_W'(2850 > lvl[t]) << 5), 1'b0);
		end
		$display("Test thresholds done");
		// Group 4-7 drops from 4 V to 2 V: channel 5 crosses inside the settle window
		apb(1'b1, ADDR_SEL_LO, 32'h00000C00);
		apb(1'b1, ADDR_THR, '0);
		repeat (12) @(posedge pclk);
		rd(ADDR_STATUS, '0, 1'b0);
		rd(ADDR_LEVEL, 32'h00000023, 1'b0);
		$display("Test settle window done");
		// Channel 2 rises while the clock enable is low
		apb(1'b1, ADDR_SEL_LO, 32'h00000010);
		apb(1'b1, ADDR_MASK, 32'h00000004);
		ce <= 1'b0;
		mv[24 +: 12] <= 12'd2500;
		repeat (10) @(posedge pclk);
		`CHK(irq, 1'b0)
		ce <= 1'b1;
		repeat (10) @(posedge pclk);
		`CHK(irq, 1'b1)
		apb(1'b1, ADDR_STATUS, 32'h00000FFF);
		repeat (4) @(posedge pclk);
		`CHK(irq, 1'b0)
		$display("Test clock enable done");
		results();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
